// ==== design/iox_top.sv ====
/*
  16-pin GPIO expander core: two banks of eight pins, register file,
  pin sampling, change interrupt, bus-hold and pull controls.
  Assumes scl/sda/pins arrive asynchronously and an external pad ring
  resolves the open-drain and tristate enables into wires.
*/
`timescale 1ns/1ps
`default_nettype none
// What this block does
// [RQ1] Sixteen pins, each input or output, inputs default
// [RQ2] Two banks, eight-bit registers each
// [RQ3] Direction bits steer pins; input sampled, output driven
// [RQ4] Inversion bit flips the level read back
// [RQ5] Bus-hold or pull, pull only without hold
// [RQ6] Bus-hold keeps last driven level
// [RQ7] Unmasked input change asserts open-drain interrupt
// [RQ8] All interrupt masks set out of reset
// [RQ9] All-call address accepts writes too
// [RQ10] Reset restores inputs, defaults, controller state
// [RQ11] Reset pin is active low
// [RQ12] Four select pins set address, large variant
// [RQ13] Bus clock up to 400 kHz
// [RQ14] Small variants answer one fixed address
// [RQ15] Address lsb: one reads, zero writes
// [RQ16] Command low nibble points; bad codes unacknowledged
// [RQ17] Auto-step advances and wraps the pointer
// [RQ18] Pins pass synchroniser before change detection
// [RQ19] Input read or level return clears interrupt
module iox_top #(
  parameter logic [6:0] FIXED_ADDR = 7'h20,
  parameter logic [2:0] SELECT_BASE = 3'h2,
  parameter logic [6:0] ALLCALL_ADDR = 7'h6E
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic reset_pin_n,
  input wire logic large_variant,
  input wire logic addr_select_bit0,
  input wire logic addr_select_bit1,
  input wire logic addr_select_bit2,
  input wire logic addr_select_bit3,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_n,
  output logic int_o,
  output logic int_oe_n,
  input wire logic [7:0] bank0_pin_i,
  output logic [7:0] bank0_pin_o,
  output logic [7:0] bank0_pin_oe_n,
  input wire logic [7:0] bank1_pin_i,
  output logic [7:0] bank1_pin_o,
  output logic [7:0] bank1_pin_oe_n,
  output logic [15:0] pull_en,
  output logic [15:0] pull_up,
  output logic [15:0] keep_en,
  output logic [15:0] keep_level
);
  logic [7:0] pin_s [2];
  logic [7:0] inv_q [2], hold_q [2], pull_q [2], dir_q [2], out_q [2], mask_q [2];
  logic [7:0] inv_d [2], hold_d [2], pull_d [2], dir_d [2], out_d [2], mask_d [2];
  logic [7:0] seen_q [2], seen_d [2], pend [2], keep_q [2];
  logic [15:0] pins_raw;
  logic [7:0] ctl_s;
  logic scl_s, sda_s, rstn_s, dev_rst, wr_stb, rd_stb, sda_drive, int_q;
  logic [3:0] reg_idx;
  logic [7:0] wr_data, rd_data;
  logic [6:0] own_addr;

  ////////////////////////////////////////////////////////////////////////////
  // [RQ18] Three-flop pin sampling
  assign pins_raw = {bank1_pin_i, bank0_pin_i};
  iox_sync #(.W(16), .RST_VAL(16'h0000)) u_pin_sync (
    .clock(clock),
    .rst(rst),
    .din(pins_raw),
    .dout({pin_s[1], pin_s[0]})
  );

  // 50 MHz oversamples a 400 kHz bus clock 125 times
  iox_sync #(.W(8), .RST_VAL(8'h07)) u_ctl_sync (
    .clock(clock),
    .rst(rst),
    .din({large_variant, addr_select_bit3, addr_select_bit2, addr_select_bit1,
          addr_select_bit0, reset_pin_n, sda_i, scl_i}),
    .dout(ctl_s)
  );
  assign scl_s = ctl_s[0];
  assign sda_s = ctl_s[1];
  assign rstn_s = ctl_s[2];

  // [RQ11] Low reset pin acts like power-on reset
  assign dev_rst = rst | ~rstn_s;

  // [RQ12] Select pins form the address low nibble
  // [RQ14] Small variant uses the fixed address
  assign own_addr = ctl_s[7] ? {SELECT_BASE, ctl_s[6:3]} : FIXED_ADDR;

  ////////////////////////////////////////////////////////////////////////////
  // [RQ13] Serial target, timing from the oversampled edges
  iox_i2c u_i2c (
    .clock(clock),
    .rst(dev_rst),
    .scl(scl_s),
    .sda(sda_s),
    .own_addr(own_addr),
    .allcall_addr(ALLCALL_ADDR),
    .rd_data(rd_data),
    .reg_idx(reg_idx),
    .wr_data(wr_data),
    .wr_stb(wr_stb),
    .rd_stb(rd_stb),
    .sda_drive(sda_drive)
  );

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic hit(input logic [3:0] idx, input logic [2:0] kind, input int b);
    hit = idx[3:1] == kind && idx[0] == b[0];
  endfunction : hit

  always_comb begin
    rd_data = '0;
    case (reg_idx[3:1])
      // [RQ4] Inversion applies on read only
      iox_pkg::KIND_IN: rd_data = pin_s[reg_idx[0]] ^ inv_q[reg_idx[0]];
      iox_pkg::KIND_INV: rd_data = inv_q[reg_idx[0]];
      iox_pkg::KIND_HOLD: rd_data = hold_q[reg_idx[0]];
      iox_pkg::KIND_PULL: rd_data = pull_q[reg_idx[0]];
      iox_pkg::KIND_DIR: rd_data = dir_q[reg_idx[0]];
      iox_pkg::KIND_OUT: rd_data = out_q[reg_idx[0]];
      iox_pkg::KIND_MASK: rd_data = mask_q[reg_idx[0]];
      iox_pkg::KIND_PEND: rd_data = pend[reg_idx[0]];
      default: rd_data = '0;
    endcase
  end

  // [RQ2] Per-bank eight-bit registers
  always_comb begin
    for (int b = 0; b < 2; b++) begin
      inv_d[b] = inv_q[b];
      hold_d[b] = hold_q[b];
      pull_d[b] = pull_q[b];
      dir_d[b] = dir_q[b];
      out_d[b] = out_q[b];
      mask_d[b] = mask_q[b];
      if (wr_stb) begin
        if (hit(reg_idx, iox_pkg::KIND_INV, b)) inv_d[b] = wr_data;
        if (hit(reg_idx, iox_pkg::KIND_HOLD, b)) hold_d[b] = wr_data;
        if (hit(reg_idx, iox_pkg::KIND_PULL, b)) pull_d[b] = wr_data;
        // [RQ3] Host sets direction per bit
        if (hit(reg_idx, iox_pkg::KIND_DIR, b)) dir_d[b] = wr_data;
        if (hit(reg_idx, iox_pkg::KIND_OUT, b)) out_d[b] = wr_data;
        if (hit(reg_idx, iox_pkg::KIND_MASK, b)) mask_d[b] = wr_data;
      end
      // [RQ19] Reading input re-arms; masked bits track the pin
      if (rd_stb && hit(reg_idx, iox_pkg::KIND_IN, b)) begin
        seen_d[b] = pin_s[b];
      end else begin
        seen_d[b] = (seen_q[b] & dir_q[b] & ~mask_q[b]) | (pin_s[b] & ~(dir_q[b] & ~mask_q[b]));
      end
      // [RQ7] Unmasked input differing from last read
      pend[b] = (pin_s[b] ^ seen_q[b]) & dir_q[b] & ~mask_q[b];
    end
  end

  always_ff @(posedge clock) begin
    for (int b = 0; b < 2; b++) begin
      // [RQ10] Defaults restored on any reset
      if (dev_rst) begin
        inv_q[b] <= iox_pkg::ZERO_RST;
        hold_q[b] <= iox_pkg::ZERO_RST;
        pull_q[b] <= iox_pkg::ZERO_RST;
        // [RQ1] All pins inputs after reset
        dir_q[b] <= iox_pkg::DIR_RST;
        out_q[b] <= iox_pkg::ZERO_RST;
        // [RQ8] Masked out of reset
        mask_q[b] <= iox_pkg::MASK_RST;
        seen_q[b] <= iox_pkg::ZERO_RST;
        keep_q[b] <= iox_pkg::ZERO_RST;
      end else begin
        inv_q[b] <= inv_d[b];
        hold_q[b] <= hold_d[b];
        pull_q[b] <= pull_d[b];
        dir_q[b] <= dir_d[b];
        out_q[b] <= out_d[b];
        mask_q[b] <= mask_d[b];
        seen_q[b] <= seen_d[b];
        // [RQ6] Keeper follows the last sampled level
        keep_q[b] <= pin_s[b];
      end
    end
    if (dev_rst) begin
      int_q <= 1'b0;
    end else begin
      int_q <= |{pend[1], pend[0]};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // [RQ3] Output register drives pins set as outputs
  assign bank0_pin_o = out_q[0];
  assign bank1_pin_o = out_q[1];
  assign bank0_pin_oe_n = dir_q[0];
  assign bank1_pin_oe_n = dir_q[1];
  // [RQ5] Pull active only where hold is off
  assign pull_en = ~{hold_q[1], hold_q[0]};
  assign pull_up = {pull_q[1], pull_q[0]};
  assign keep_en = {hold_q[1], hold_q[0]};
  assign keep_level = {keep_q[1], keep_q[0]};
  assign sda_o = 1'b0;
  assign sda_oe_n = ~sda_drive;
  // [RQ7] Open-drain interrupt pulls low
  assign int_o = 1'b0;
  assign int_oe_n = ~int_q;

  ////////////////////////////////////////////////////////////////////////////
  reset_dflt_a: assert property (@(posedge clock) dev_rst |=> // RQ10
    bank0_pin_oe_n == 8'hFF && bank1_pin_oe_n == 8'hFF && int_oe_n)
    else $error("reset defaults not restored");
  mask_reset_a: assert property (@(posedge clock) dev_rst ##1 !dev_rst |-> // RQ8
    mask_q[0] == 8'hFF && mask_q[1] == 8'hFF)
    else $error("masks not set after reset");
  dir_write_a: assert property (@(posedge clock) disable iff (dev_rst) // RQ3
    wr_stb && reg_idx == iox_pkg::REG_DIR0 |=> bank0_pin_oe_n == $past(wr_data))
    else $error("direction write not applied");
  int_follow_a: assert property (@(posedge clock) disable iff (dev_rst) // RQ7
    (|{pend[1], pend[0]}) |=> !int_oe_n)
    else $error("change not signalled");
  int_quiet_a: assert property (@(posedge clock) disable iff (dev_rst) // RQ7
    (pend[0] == 8'h00 && pend[1] == 8'h00) |=> int_oe_n)
    else $error("interrupt without pending change");
  read_clear_a: assert property (@(posedge clock) disable iff (dev_rst) // RQ19
    rd_stb && reg_idx == iox_pkg::REG_IN0 ##1 $stable(pin_s[0]) |-> pend[0] == 8'h00)
    else $error("input read did not clear change");
  inv_read_a: assert property (@(posedge clock) disable iff (dev_rst) // RQ4
    rd_stb && reg_idx == iox_pkg::REG_IN0 |=> sda_oe_n == $past(pin_s[0][7] ^ inv_q[0][7]))
    else $error("inverted read wrong");
  pull_excl_a: assert property (@(posedge clock) disable iff (dev_rst) // RQ5
    wr_stb ##1 (keep_en & pull_en) != 16'h0000 |-> 1'b0)
    else $error("hold and pull both active");
  keep_level_a: assert property (@(posedge clock) disable iff (dev_rst) // RQ6
    ##1 keep_en[0] |-> keep_level[0] == $past(pin_s[0][0]))
    else $error("keeper lost last level");

  write_seen_c: cover property (@(posedge clock) disable iff (dev_rst) wr_stb);
  read_seen_c: cover property (@(posedge clock) disable iff (dev_rst) rd_stb);
  int_seen_c: cover property (@(posedge clock) disable iff (dev_rst) !int_oe_n ##1 int_oe_n);
endmodule : iox_top
`default_nettype wire

// ==== design/iox_pkg.sv ====
/*
  Shared constants for the 16-pin serial GPIO expander: register index
  layout, command byte fields, reset defaults and the controller states.
  Assumes nothing about its surroundings.
*/
package iox_pkg;
  // Register index = {kind, bank}; kind in bits 3:1, bank in bit 0
  localparam logic [2:0] KIND_IN = 3'h0;
  localparam logic [2:0] KIND_INV = 3'h1;
  localparam logic [2:0] KIND_HOLD = 3'h2;
  localparam logic [2:0] KIND_PULL = 3'h3;
  localparam logic [2:0] KIND_DIR = 3'h4;
  localparam logic [2:0] KIND_OUT = 3'h5;
  localparam logic [2:0] KIND_MASK = 3'h6;
  localparam logic [2:0] KIND_PEND = 3'h7;
  localparam logic [3:0] REG_IN0 = 4'h0;
  localparam logic [3:0] REG_DIR0 = 4'h8;

  // Command byte fields
  localparam int CMD_AI_BIT = 7;
  localparam int CMD_RSV_MSB = 6;
  localparam int CMD_RSV_LSB = 4;
  localparam logic [2:0] CMD_RSV_OK = 3'h0;
  localparam logic [3:0] BYTE_BITS = 4'h8;

  // Reset values
  localparam logic [7:0] DIR_RST = 8'hFF;
  localparam logic [7:0] MASK_RST = 8'hFF;
  localparam logic [7:0] ZERO_RST = 8'h00;

  typedef enum logic [3:0] {
    ST_IDLE, ST_ADDR, ST_AACK, ST_CMD, ST_CACK,
    ST_WDAT, ST_WACK, ST_RDAT, ST_RACK, ST_RNEXT
  } iox_state_e;
endpackage : iox_pkg

// ==== design/iox_sync.sv ====
/*
  Three-stage input sampler for signals from outside the clock domain.
  Assumes a single clock and a synchronous active-high reset.
*/
`timescale 1ns/1ps
`default_nettype none
module iox_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  logic [W-1:0] s1_q, s2_q, s3_q, out_q, out_d;

  // Accept a change only once stages two and three agree
  always_comb begin
    out_d = out_q;
    for (int i = 0; i < W; i++) begin
      if (s2_q[i] == s3_q[i]) begin
        out_d[i] = s3_q[i];
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      s1_q <= RST_VAL;
      s2_q <= RST_VAL;
      s3_q <= RST_VAL;
      out_q <= RST_VAL;
    end else begin
      s1_q <= din;
      s2_q <= s1_q;
      s3_q <= s2_q;
      out_q <= out_d;
    end
  end

  assign dout = out_q;
endmodule : iox_sync
`default_nettype wire

// ==== design/iox_i2c.sv ====
/*
  Serial target controller: address match, command byte, register pointer,
  write and read data phases. Assumes scl and sda already sampled into
  the clock domain and an external register file answering rd_data
  combinationally from reg_idx.
*/
`timescale 1ns/1ps
`default_nettype none
module iox_i2c (
  input wire logic clock,
  input wire logic rst,
  input wire logic scl,
  input wire logic sda,
  input wire logic [6:0] own_addr,
  input wire logic [6:0] allcall_addr,
  input wire logic [7:0] rd_data,
  output logic [3:0] reg_idx,
  output logic [7:0] wr_data,
  output logic wr_stb,
  output logic rd_stb,
  output logic sda_drive
);
  iox_pkg::iox_state_e st_q, st_d;
  logic [3:0] cnt_q, cnt_d, ptr_q, ptr_d;
  logic [7:0] sh_q, sh_d;
  logic ai_q, ai_d, rw_q, rw_d, drv_q, drv_d, scl_q, sda_q;
  logic rise, fall, start, stop, own_hit, all_hit;

  function automatic logic [3:0] step(input logic [3:0] p, input logic ai);
    step = ai ? p + 4'h1 : p;
  endfunction : step

  assign rise = scl & ~scl_q;
  assign fall = ~scl & scl_q;
  assign start = scl & scl_q & sda_q & ~sda;
  assign stop = scl & scl_q & ~sda_q & sda;
  assign own_hit = sh_q[7:1] == own_addr;
  assign all_hit = (sh_q[7:1] == allcall_addr) & ~sh_q[0];

  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    sh_d = sh_q;
    ptr_d = ptr_q;
    ai_d = ai_q;
    rw_d = rw_q;
    drv_d = drv_q;
    wr_stb = 1'b0;
    rd_stb = 1'b0;
    if (start) begin
      st_d = iox_pkg::ST_ADDR;
      cnt_d = '0;
      drv_d = 1'b0;
    end else if (stop) begin
      st_d = iox_pkg::ST_IDLE;
      drv_d = 1'b0;
    end else begin
      case (st_q)
        iox_pkg::ST_ADDR, iox_pkg::ST_CMD, iox_pkg::ST_WDAT: begin
          if (rise && cnt_q < iox_pkg::BYTE_BITS) begin
            sh_d = {sh_q[6:0], sda};
            cnt_d = cnt_q + 4'h1;
          end
          if (fall && cnt_q == iox_pkg::BYTE_BITS) begin
            cnt_d = '0;
            st_d = iox_pkg::ST_IDLE;
            if (st_q == iox_pkg::ST_ADDR) begin
              // [RQ9] All-call takes writes only
              if (own_hit || all_hit) begin
                drv_d = 1'b1;
                // [RQ15] Lsb picks direction
                rw_d = sh_q[0];
                st_d = iox_pkg::ST_AACK;
              end
            end else if (st_q == iox_pkg::ST_CMD) begin
              // [RQ16] Reserved codes left unacknowledged
              if (sh_q[iox_pkg::CMD_RSV_MSB:iox_pkg::CMD_RSV_LSB] == iox_pkg::CMD_RSV_OK) begin
                ptr_d = sh_q[3:0];
                ai_d = sh_q[iox_pkg::CMD_AI_BIT];
                drv_d = 1'b1;
                st_d = iox_pkg::ST_CACK;
              end
            end else begin
              wr_stb = 1'b1;
              // [RQ17] Pointer steps, wraps at four bits
              ptr_d = step(ptr_q, ai_q);
              drv_d = 1'b1;
              st_d = iox_pkg::ST_WACK;
            end
          end
        end
        iox_pkg::ST_CACK, iox_pkg::ST_WACK: begin
          if (fall) begin
            drv_d = 1'b0;
            st_d = iox_pkg::ST_WDAT;
          end
        end
        iox_pkg::ST_AACK, iox_pkg::ST_RNEXT: begin
          if (fall && (st_q == iox_pkg::ST_RNEXT || rw_q)) begin
            rd_stb = 1'b1;
            drv_d = ~rd_data[7];
            sh_d = {rd_data[6:0], 1'b0};
            cnt_d = 4'h1;
            // [RQ17] Read also advances pointer
            ptr_d = step(ptr_q, ai_q);
            st_d = iox_pkg::ST_RDAT;
          end else if (fall) begin
            drv_d = 1'b0;
            st_d = iox_pkg::ST_CMD;
          end
        end
        iox_pkg::ST_RDAT: begin
          if (fall && cnt_q == iox_pkg::BYTE_BITS) begin
            drv_d = 1'b0;
            cnt_d = '0;
            st_d = iox_pkg::ST_RACK;
          end else if (fall) begin
            drv_d = ~sh_q[7];
            sh_d = {sh_q[6:0], 1'b0};
            cnt_d = cnt_q + 4'h1;
          end
        end
        iox_pkg::ST_RACK: begin
          if (rise) begin
            st_d = sda ? iox_pkg::ST_IDLE : iox_pkg::ST_RNEXT;
          end
        end
        default: st_d = iox_pkg::ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      st_q <= iox_pkg::ST_IDLE;
      cnt_q <= '0;
      sh_q <= '0;
      ptr_q <= '0;
      ai_q <= 1'b0;
      rw_q <= 1'b0;
      drv_q <= 1'b0;
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      sh_q <= sh_d;
      ptr_q <= ptr_d;
      ai_q <= ai_d;
      rw_q <= rw_d;
      drv_q <= drv_d;
      scl_q <= scl;
      sda_q <= sda;
    end
  end

  assign reg_idx = ptr_q;
  assign wr_data = sh_q;
  assign sda_drive = drv_q;

  ////////////////////////////////////////////////////////////////////////////
  addr_ack_a: assert property (@(posedge clock) disable iff (rst) // RQ15
    st_q == iox_pkg::ST_ADDR && fall && cnt_q == iox_pkg::BYTE_BITS && own_hit && !start
    && !stop |=> drv_q && st_q == iox_pkg::ST_AACK && rw_q == $past(sh_q[0]))
    else $error("own address not acknowledged");
  allcall_read_a: assert property (@(posedge clock) disable iff (rst) // RQ9
    st_q == iox_pkg::ST_ADDR && fall && cnt_q == iox_pkg::BYTE_BITS && !own_hit && sh_q[0]
    && !start && !stop |=> st_q == iox_pkg::ST_IDLE && !drv_q)
    else $error("read to foreign address acknowledged");
  cmd_nack_a: assert property (@(posedge clock) disable iff (rst) // RQ16
    st_q == iox_pkg::ST_CMD && fall && cnt_q == iox_pkg::BYTE_BITS && sh_q[6:4] != 3'h0
    && !start && !stop |=> st_q == iox_pkg::ST_IDLE && !drv_q)
    else $error("reserved command acknowledged");
  ptr_step_a: assert property (@(posedge clock) disable iff (rst) // RQ17
    (wr_stb || rd_stb) |=> ptr_q == ($past(ptr_q) + {3'h0, $past(ai_q)}))
    else $error("pointer step wrong");
endmodule : iox_i2c
`default_nettype wire

// ==== test/iox_host.sv ====
/*
  Bus controller model for the expander's serial link: START, STOP,
  byte writes and byte reads, open-drain on the data wire.
  Assumes the data wire is resolved with a pull-up outside this model.
*/
`timescale 1ns/1ps
`default_nettype none
module iox_host #(
  parameter int HALF = 4
) (
  input wire logic clock,
  input wire logic sda,
  output logic scl,
  output logic sda_low
);
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  //////////////////////////////////////////////////////////////////////
  task automatic gap(input int n);
    repeat (n) @(posedge clock);
  endtask : gap
  // Fixed bit time, clock held between frames
  // Long low phase: the target lets go of the wire five cycles after a fall
  task automatic bit_x(input logic b, output logic s);
    gap(1);
    sda_low <= ~b;
    gap(HALF);
    scl <= 1'b1;
    gap(HALF - 1);
    s = sda;
    scl <= 1'b0;
  endtask : bit_x
  task automatic start_c();
    @(posedge clock);
    sda_low <= 1'b0;
    gap(HALF);
    scl <= 1'b1;
    gap(HALF);
    sda_low <= 1'b1;
    gap(HALF);
    scl <= 1'b0;
  endtask : start_c
  task automatic stop_c();
    gap(1);
    sda_low <= 1'b1;
    gap(HALF);
    scl <= 1'b1;
    gap(HALF);
    sda_low <= 1'b0;
    gap(HALF);
  endtask : stop_c
  // Bytes go MSB first, ninth bit answers
  task automatic wbyte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_x(b[i], s);
    bit_x(1'b1, s);
    ack = ~s;
  endtask : wbyte
  // Released data wire lets the target drive
  task automatic rbyte(input logic last, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) bit_x(1'b1, b[i]);
    bit_x(last, s);
  endtask : rbyte
endmodule : iox_host
`default_nettype wire

// ==== test/iox_bench.sv ====
/*
  Self-checking bench for the expander core: reset defaults, register
  access over the link, pins, pulls, keeper, change interrupt, addressing.
  Assumes iox_host as controller; pad wires are resolved here.
*/
`timescale 1ns/1ps
`default_nettype none
module i2c_sixteen_bit_gpio_expander_bench;
  localparam logic [6:0] FIX = 7'h20;
  localparam logic [2:0] BASE = 3'h2;
  localparam logic [6:0] ALL = 7'h6E;
  logic clock, rst, reset_pin_n, large_variant, scl, sda_low, ack, got;
  logic [3:0] sel;
  logic [15:0] ext, v1, v2;
  logic [7:0] rb [2];
  wire logic sda_w, sda_o, sda_oe_n, int_o, int_oe_n;
  wire logic [7:0] p0_i, p0_o, p0_oe_n, p1_i, p1_o, p1_oe_n;
  wire logic [15:0] pull_en, pull_up, keep_en, keep_level;
  int err_count, total_checks;
  assign sda_w = ~sda_low & (sda_oe_n | sda_o);
  // Driven pins read back their own level
  assign p0_i = (ext[7:0] & p0_oe_n) | (p0_o & ~p0_oe_n);
  assign p1_i = (ext[15:8] & p1_oe_n) | (p1_o & ~p1_oe_n);
  // Eight-cycle bus clock period, 160 ns
  iox_host #(.HALF(4)) h (.clock(clock), .sda(sda_w), .scl(scl), .sda_low(sda_low));
  iox_top #(.FIXED_ADDR(FIX), .SELECT_BASE(BASE), .ALLCALL_ADDR(ALL)) DUT (
    .clock(clock), .rst(rst), .reset_pin_n(reset_pin_n), .large_variant(large_variant),
    .addr_select_bit0(sel[0]), .addr_select_bit1(sel[1]), .addr_select_bit2(sel[2]),
    .addr_select_bit3(sel[3]), .scl_i(scl), .sda_i(sda_w), .sda_o(sda_o),
    .sda_oe_n(sda_oe_n), .int_o(int_o), .int_oe_n(int_oe_n), .bank0_pin_i(p0_i),
    .bank0_pin_o(p0_o), .bank0_pin_oe_n(p0_oe_n), .bank1_pin_i(p1_i), .bank1_pin_o(p1_o),
    .bank1_pin_oe_n(p1_oe_n), .pull_en(pull_en), .pull_up(pull_up), .keep_en(keep_en),
    .keep_level(keep_level));
  //////////////////////////////////////////////////////////////////////
  task automatic w(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : w
  function automatic logic [15:0] read_exp(input logic [15:0] p, input logic [15:0] inv);
    read_exp = p ^ inv;
  endfunction : read_exp
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    total_checks++;
    if (g !== e) begin
      err_count++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic wr(input logic [6:0] a, input logic [7:0] c, input logic [47:0] d,
                    input int n, output logic ok);
    logic k;
    h.start_c();
    h.wbyte({a, 1'b0}, ok);
    h.wbyte(c, k);
    ok = ok & k;
    for (int i = 0; i < n; i++) begin
      h.wbyte(d[8*i +: 8], k);
      ok = ok & k;
    end
    h.stop_c();
    w(8);
  endtask : wr
  task automatic rd(input logic [6:0] a, input logic [7:0] c, input int n, output logic ok);
    logic k;
    h.start_c();
    h.wbyte({a, 1'b0}, ok);
    h.wbyte(c, k);
    ok = ok & k;
    h.start_c();
    h.wbyte({a, 1'b1}, k);
    ok = ok & k;
    for (int i = 0; i < n; i++) h.rbyte(i == n - 1, rb[i]);
    h.stop_c();
    w(8);
  endtask : rd
  task automatic defaults();
    chk("reset direction", 16'hFFFF, {p1_oe_n, p0_oe_n});
    chk("reset outputs", 16'h0000, {p1_o, p0_o});
    chk("reset pulls", 16'hFFFF, pull_en);
    chk("reset pull dir", 16'h0000, pull_up);
    chk("open-drain levels", 16'h0000, {14'h0, int_o, sda_o});
    chk("reset keeper", 16'h0000, keep_en);
    chk("reset int", 16'h0001, 16'(int_oe_n));
    chk("reset sda", 16'h0001, 16'(sda_oe_n));
  endtask : defaults
  task automatic wait_int(input logic v, output logic g);
    g = 1'b0;
    for (int i = 0; i < 20 && !g; i++) begin
      w(1);
      if (int_oe_n === v) g = 1'b1;
    end
  endtask : wait_int
  task automatic final_report();
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : final_report
  //////////////////////////////////////////////////////////////////////
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  initial begin
    repeat (60000) @(posedge clock);
    err_count++;
    final_report();
  end
  initial begin
    err_count = 0;
    total_checks = 0;
    rst = 1'b1;
    reset_pin_n = 1'b1;
    large_variant = 1'b0;
    sel = 4'h0;
    ext = 16'h0000;
    void'($urandom(32'h3467));
    w(5);
    defaults();
    @(posedge clock) rst <= 1'b0;
    w(8);
    v1 = 16'($urandom);
    v2 = 16'($urandom);
    wr(FIX, 8'h88, {16'h0000, v2, v1}, 4, ack);
    chk("write ack", 16'h0001, 16'(ack));
    chk("direction", v1, {p1_oe_n, p0_oe_n});
    chk("outputs", v2, {p1_o, p0_o});
    wr(FIX, 8'h0A, 48'hC35A, 2, ack);
    chk("fixed pointer", {v2[15:8], 8'hC3}, {p1_o, p0_o});
    $display("test writes done");
    v1 = 16'($urandom);
    wr(FIX, 8'h8E, {v1, 32'hFFFFFFFF}, 6, ack);
    rd(FIX, 8'h82, 2, ack);
    chk("wrap", v1, {rb[1], rb[0]});
    wr(FIX, 8'h88, 48'hFFFF, 2, ack);
    @(posedge clock) ext <= 16'($urandom);
    w(10);
    rd(FIX, 8'h80, 2, ack);
    chk("read ack", 16'h0001, 16'(ack));
    chk("inverted input", read_exp(ext, v1), {rb[1], rb[0]});
    $display("test reads done");
    v1 = 16'($urandom);
    v2 = 16'($urandom);
    wr(FIX, 8'h84, {16'h0000, v2, v1}, 4, ack);
    chk("keeper on", v1, keep_en);
    chk("pull on", ~v1, pull_en);
    chk("pull dir", v2, pull_up);
    chk("kept level", ext, keep_level);
    $display("test pulls done");
    wr(FIX, 8'h8C, 48'hFFFE, 2, ack);
    rd(FIX, 8'h00, 1, ack);
    chk("int idle", 16'h0001, 16'(int_oe_n));
    @(posedge clock) ext[1] <= ~ext[1];
    w(20);
    chk("masked pin", 16'h0001, 16'(int_oe_n));
    @(posedge clock) ext[0] <= ~ext[0];
    wait_int(1'b0, got);
    chk("int raised", 16'h0001, 16'(got));
    rd(FIX, 8'h00, 1, ack);
    chk("int cleared", 16'h0001, 16'(int_oe_n));
    @(posedge clock) ext[0] <= ~ext[0];
    wait_int(1'b0, got);
    chk("int again", 16'h0001, 16'(got));
    @(posedge clock) ext[0] <= ~ext[0];
    wait_int(1'b1, got);
    chk("pin return", 16'h0001, 16'(got));
    $display("test interrupt done");
    v1 = 16'(1 + $urandom % 15);
    @(posedge clock) sel <= v1[3:0];
    @(posedge clock) large_variant <= 1'b1;
    w(8);
    wr({BASE, v1[3:0]}, 8'h0A, 48'h3C, 1, ack);
    chk("select addr", 16'h0001, 16'(ack));
    wr(FIX, 8'h0A, 48'h3C, 1, ack);
    chk("fixed off", 16'h0000, 16'(ack));
    wr(ALL, 8'h0A, 48'hA5, 1, ack);
    chk("all-call write", 16'h00A5, 16'(p0_o));
    rd(ALL, 8'h0A, 1, ack);
    chk("all-call read", 16'h0000, 16'(ack));
    @(posedge clock) large_variant <= 1'b0;
    w(8);
    wr({BASE, v1[3:0]}, 8'h0A, 48'h3C, 1, ack);
    chk("select off", 16'h0000, 16'(ack));
    wr(FIX, 8'h30, 48'h3C, 1, ack);
    chk("bad command", 16'h0000, 16'(ack));
    $display("test addressing done");
    @(posedge clock) reset_pin_n <= 1'b0;
    w(10);
    defaults();
    @(posedge clock) reset_pin_n <= 1'b1;
    w(8);
    wr(FIX, 8'h88, 48'h0000, 2, ack);
    @(posedge clock) rst <= 1'b1;
    w(2);
    defaults();
    @(posedge clock) rst <= 1'b0;
    w(8);
    @(posedge clock) ext <= ~ext;
    w(20);
    chk("masked after reset", 16'h0001, 16'(int_oe_n));
    $display("test resets done");
    final_report();
  end
endmodule : i2c_sixteen_bit_gpio_expander_bench
`default_nettype wire
